// *** inc/atts_pkg.sv ***
// constants for the converter threshold compare and trigger select block
package atts_pkg;

  // register byte offsets on the bus (one aligned word each)
  localparam logic [7:0] OFS_ERR_HIGH    = 8'h00;
  localparam logic [7:0] OFS_ERR_LOW     = 8'h04;
  localparam logic [7:0] OFS_LTH_HIGH    = 8'h08;
  localparam logic [7:0] OFS_LTH_LOW     = 8'h0c;
  localparam logic [7:0] OFS_UTH_HIGH    = 8'h10;
  localparam logic [7:0] OFS_UTH_LOW     = 8'h14;
  localparam logic [7:0] OFS_TRIG_SEL    = 8'h18;
  localparam logic [7:0] OFS_CTRL_THREE  = 8'h1c;
  localparam logic [7:0] OFS_CONV_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h28;
  localparam logic [7:0] OFS_PIN_ROUTE   = 8'h2c;
  localparam logic [7:0] OFS_SETPT_HIGH  = 8'h30;
  localparam logic [7:0] OFS_SETPT_LOW   = 8'h34;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_SEL  = 5'h00;

  // field positions in control three: error_select_a select [6:4], irq mode [2:0]
  localparam int ERROR_SELECT_A_LSB = 4;
  localparam int TMD_LSB  = 0;
  // field positions in the status registers
  localparam int STAT_ABOVE_UPPER = 1;
  localparam int STAT_BELOW_LOWER = 0;
  localparam int IRQ_THRESH       = 0;
  localparam int IRQ_SOC          = 1;
  localparam int IRQ_DONE         = 2;
  localparam int IRQ_W            = 3;

  // trigger selector codes
  localparam logic [4:0] ACT_OFF       = 5'h00;
  localparam logic [4:0] ACT_PIN       = 5'h01;
  localparam logic [4:0] ACT_FIRST_SRC = 5'h02;
  localparam logic [4:0] ACT_LAST_SRC  = 5'h19;
  localparam logic [4:0] ACT_ERR_READ  = 5'h1a;
  localparam logic [4:0] ACT_RES_READ  = 5'h1b;
  localparam logic [4:0] ACT_CHAN_WR   = 5'h1d;
  localparam int         NUM_SRC       = 24;

  // error calculation methods
  localparam logic [2:0] ERROR_SELECT_A_RES_PREV  = 3'h0;
  localparam logic [2:0] ERROR_SELECT_A_RES_SETPT = 3'h1;
  localparam logic [2:0] ERROR_SELECT_A_PREV_SETPT = 3'h2;
  localparam logic [2:0] ERROR_SELECT_A_FLT_SETPT = 3'h3;
  localparam logic [2:0] ERROR_SELECT_A_FLT_PREV  = 3'h4;

  // threshold interrupt modes
  localparam logic [2:0] TMD_NEVER     = 3'h0;
  localparam logic [2:0] TMD_BELOW     = 3'h1;
  localparam logic [2:0] TMD_NOT_BELOW = 3'h2;
  localparam logic [2:0] TMD_INSIDE    = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE   = 3'h4;
  localparam logic [2:0] TMD_NOT_ABOVE = 3'h5;
  localparam logic [2:0] TMD_ABOVE     = 3'h6;
  localparam logic [2:0] TMD_ALWAYS    = 3'h7;

endpackage

// *** src/atts_top.sv ***
// threshold compare, setpoint error and auto-conversion trigger select with ahb-lite slave
`timescale 1ns/1ps
module atts_top #(
  parameter int NUM_PINS = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [15:0]          conv_result,
  input  wire logic [15:0]          prev_result,
  input  wire logic [15:0]          filter_value,
  input  wire logic                 conv_done,
  input  wire logic [NUM_PINS-1:0]  trigger_pins,
  input  wire logic [atts_pkg::NUM_SRC-1:0] trigger_sources,
  input  wire logic                 result_upper_byte_read,
  input  wire logic                 input_channel_select_write,
  output logic                      soc_req,
  output logic                      threshold_irq,
  output logic                      irq
);

  // width of the pin routing field
  localparam int PSEL_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

  // refuse pin counts the routing field cannot address, at elaboration
  if (NUM_PINS < 1 || NUM_PINS > 256)
  begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 256");
  end

  // true when a selector code picks one of the on-chip level sources
  function automatic logic is_src_code(input logic [4:0] c);
    is_src_code = (c >= atts_pkg::ACT_FIRST_SRC) && (c <= atts_pkg::ACT_LAST_SRC);
  endfunction

  // decode of a byte offset, used by both phases
  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
    is_ofs = (a == ofs);
  endfunction

  // registers
  logic [15:0]             err_q;
  logic [15:0]             lower_limit_q;
  logic [15:0]             upper_limit_q;
  logic [15:0]             setpt_q;
  logic [4:0]              trigger_source_select_q;
  logic [2:0]              error_select_a_q;
  logic [2:0]              threshold_interrupt_mode_q;
  logic                    above_upper_flag_q;
  logic                    below_lower_flag_q;
  logic [atts_pkg::IRQ_W-1:0] irq_stat_q;
  logic [atts_pkg::IRQ_W-1:0] irq_mask_q;
  logic [PSEL_W-1:0]       trigger_pin_routing_q;
  logic [NUM_PINS-1:0]     pin_meta_q;
  logic [NUM_PINS-1:0]     pin_sync_q;
  logic                    trig_prev_q;
  logic                    done_q;
  logic                    thr_evt_q;
  logic                    soc_q;
  logic                    sel_wr_q;
  logic [31:0]             rdata_q;

  // bus phase signals
  logic                    wr_pend_q;
  logic [7:0]              wr_addr_q;
  logic                    acc;
  logic                    rd_acc;
  logic [7:0]              a_ofs;
  logic                    err_high_read;
  logic [7:0]              wbyte;
  logic                    wr_en;

  // compare and trigger signals
  logic signed [15:0]      err_d;
  logic                    above_d;
  logic                    below_d;
  logic                    at_or_below_l;
  logic                    at_or_above_u;
  logic                    thr_hit;
  logic                    trig_level;
  logic                    trig_pulse;
  logic                    pin_level;
  logic [atts_pkg::IRQ_W-1:0] irq_set;
  logic [atts_pkg::IRQ_W-1:0] irq_clr;

  // address phase qualification
  assign acc           = hsel & htrans[1] & hready;
  assign rd_acc        = acc & ~hwrite;
  assign a_ofs         = haddr[7:0];
  assign err_high_read = rd_acc & is_ofs(a_ofs, atts_pkg::OFS_ERR_HIGH);
  assign wbyte         = hwdata[7:0];
  assign wr_en         = wr_pend_q;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = rdata_q;

  // write address capture for the data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= acc & hwrite;
      if (acc & hwrite)
        wr_addr_q <= a_ofs;
    end
  end

  // read data registered in the address phase, unmapped reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (rd_acc)
    begin
      rdata_q <= 32'h00000000;
      case (a_ofs)
        atts_pkg::OFS_ERR_HIGH:    rdata_q[7:0] <= err_q[15:8];
        atts_pkg::OFS_ERR_LOW:     rdata_q[7:0] <= err_q[7:0];
        atts_pkg::OFS_LTH_HIGH:    rdata_q[7:0] <= lower_limit_q[15:8];
        atts_pkg::OFS_LTH_LOW:     rdata_q[7:0] <= lower_limit_q[7:0];
        atts_pkg::OFS_UTH_HIGH:    rdata_q[7:0] <= upper_limit_q[15:8];
        atts_pkg::OFS_UTH_LOW:     rdata_q[7:0] <= upper_limit_q[7:0];
        atts_pkg::OFS_TRIG_SEL:    rdata_q[4:0] <= trigger_source_select_q;
        atts_pkg::OFS_CTRL_THREE:
        begin
          rdata_q[atts_pkg::ERROR_SELECT_A_LSB +: 3] <= error_select_a_q;
          rdata_q[atts_pkg::TMD_LSB +: 3]  <= threshold_interrupt_mode_q;
        end
        atts_pkg::OFS_CONV_STATUS:
        begin
          rdata_q[atts_pkg::STAT_ABOVE_UPPER] <= above_upper_flag_q;
          rdata_q[atts_pkg::STAT_BELOW_LOWER] <= below_lower_flag_q;
        end
        atts_pkg::OFS_IRQ_STATUS:  rdata_q[atts_pkg::IRQ_W-1:0] <= irq_stat_q;
        atts_pkg::OFS_IRQ_MASK:    rdata_q[atts_pkg::IRQ_W-1:0] <= irq_mask_q;
        atts_pkg::OFS_PIN_ROUTE:   rdata_q[PSEL_W-1:0] <= trigger_pin_routing_q;
        atts_pkg::OFS_SETPT_HIGH:  rdata_q[7:0] <= setpt_q[15:8];
        atts_pkg::OFS_SETPT_LOW:   rdata_q[7:0] <= setpt_q[7:0];
        default:                   rdata_q <= 32'h00000000;
      endcase
    end
  end

  // limit and setpoint bytes, cleared on every reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_limit_q <= {atts_pkg::RST_BYTE, atts_pkg::RST_BYTE};
      upper_limit_q <= {atts_pkg::RST_BYTE, atts_pkg::RST_BYTE};
      setpt_q       <= {atts_pkg::RST_BYTE, atts_pkg::RST_BYTE};
    end
    else if (wr_en)
    begin
      if (is_ofs(wr_addr_q, atts_pkg::OFS_LTH_HIGH)) lower_limit_q[15:8] <= wbyte;
      if (is_ofs(wr_addr_q, atts_pkg::OFS_LTH_LOW))  lower_limit_q[7:0]  <= wbyte;
      if (is_ofs(wr_addr_q, atts_pkg::OFS_UTH_HIGH)) upper_limit_q[15:8] <= wbyte;
      if (is_ofs(wr_addr_q, atts_pkg::OFS_UTH_LOW))  upper_limit_q[7:0]  <= wbyte;
      if (is_ofs(wr_addr_q, atts_pkg::OFS_SETPT_HIGH)) setpt_q[15:8] <= wbyte;
      if (is_ofs(wr_addr_q, atts_pkg::OFS_SETPT_LOW))  setpt_q[7:0]  <= wbyte;
    end
  end

  // control registers: selector, error_select_a and irq mode, pin routing, mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trigger_source_select_q    <= atts_pkg::RST_SEL;
      error_select_a_q           <= atts_pkg::ERROR_SELECT_A_RES_PREV;
      threshold_interrupt_mode_q <= atts_pkg::TMD_NEVER;
      trigger_pin_routing_q      <= '0;
      irq_mask_q                 <= '0;
    end
    else if (wr_en)
    begin
      if (is_ofs(wr_addr_q, atts_pkg::OFS_TRIG_SEL))
        trigger_source_select_q <= wbyte[4:0];
      if (is_ofs(wr_addr_q, atts_pkg::OFS_CTRL_THREE))
      begin
        error_select_a_q           <= wbyte[atts_pkg::ERROR_SELECT_A_LSB +: 3];
        threshold_interrupt_mode_q <= wbyte[atts_pkg::TMD_LSB +: 3];
      end
      if (is_ofs(wr_addr_q, atts_pkg::OFS_PIN_ROUTE))
        trigger_pin_routing_q <= wbyte[PSEL_W-1:0];
      if (is_ofs(wr_addr_q, atts_pkg::OFS_IRQ_MASK))
        irq_mask_q <= wbyte[atts_pkg::IRQ_W-1:0];
    end
  end

  // error calculation by the selected method
  always_comb
  begin
    case (error_select_a_q)
      atts_pkg::ERROR_SELECT_A_RES_PREV:   err_d = $signed(conv_result - prev_result);
      atts_pkg::ERROR_SELECT_A_RES_SETPT:  err_d = $signed(conv_result - setpt_q);
      atts_pkg::ERROR_SELECT_A_PREV_SETPT: err_d = $signed(prev_result - setpt_q);
      atts_pkg::ERROR_SELECT_A_FLT_SETPT:  err_d = $signed(filter_value - setpt_q);
      atts_pkg::ERROR_SELECT_A_FLT_PREV:   err_d = $signed(filter_value - prev_result);
      default:                   err_d = $signed(conv_result - setpt_q);
    endcase
  end

  // error register has no reset, it reads unknown until the first conversion
  always_ff @(posedge clk)
  begin
    if (conv_done)
      err_q <= err_d;
  end

  // signed comparison of the fresh error against both limits
  always_comb
  begin
    above_d       = err_d > $signed(upper_limit_q);
    below_d       = err_d < $signed(lower_limit_q);
    at_or_below_l = err_d <= $signed(lower_limit_q);
    at_or_above_u = err_d >= $signed(upper_limit_q);
    case (threshold_interrupt_mode_q)
      atts_pkg::TMD_NEVER:     thr_hit = 1'b0;
      atts_pkg::TMD_BELOW:     thr_hit = below_d;
      atts_pkg::TMD_NOT_BELOW: thr_hit = ~below_d;
      atts_pkg::TMD_INSIDE:    thr_hit = ~at_or_below_l & ~at_or_above_u;
      atts_pkg::TMD_OUTSIDE:   thr_hit = at_or_below_l | at_or_above_u;
      atts_pkg::TMD_NOT_ABOVE: thr_hit = ~above_d;
      atts_pkg::TMD_ABOVE:     thr_hit = above_d;
      atts_pkg::TMD_ALWAYS:    thr_hit = 1'b1;
      default:                 thr_hit = 1'b0;
    endcase
  end

  // status flags and threshold event, updated on each completed conversion
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      above_upper_flag_q <= 1'b0;
      below_lower_flag_q <= 1'b0;
      thr_evt_q          <= 1'b0;
      done_q             <= 1'b0;
    end
    else
    begin
      done_q    <= conv_done;
      thr_evt_q <= conv_done & thr_hit;
      if (conv_done)
      begin
        above_upper_flag_q <= above_d;
        below_lower_flag_q <= below_d;
      end
    end
  end

  // threshold request straight from its event flip-flop
  assign threshold_irq = thr_evt_q;

  // two-stage synchroniser for every trigger pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= trigger_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // routed pin level, a routing value past the last pin reads low
  always_comb
  begin
    pin_level = 1'b0;
    if (int'(trigger_pin_routing_q) < NUM_PINS)
      pin_level = pin_sync_q[trigger_pin_routing_q];
  end

  // trigger source multiplexer, reserved and zero codes give nothing
  always_comb
  begin
    trig_level = 1'b0;
    trig_pulse = 1'b0;
    if (trigger_source_select_q == atts_pkg::ACT_OFF)
      trig_level = 1'b0;
    else if (trigger_source_select_q == atts_pkg::ACT_PIN)
      trig_level = pin_level;
    else if (is_src_code(trigger_source_select_q))
      // index = code - 2 over timers, ccp, pwm, nco, cmp, ioc, clc
      trig_level = trigger_sources[5'(trigger_source_select_q - atts_pkg::ACT_FIRST_SRC)];
    else if (trigger_source_select_q == atts_pkg::ACT_ERR_READ)
      trig_pulse = err_high_read;
    else if (trigger_source_select_q == atts_pkg::ACT_RES_READ)
      trig_pulse = result_upper_byte_read;
    else if (trigger_source_select_q == atts_pkg::ACT_CHAN_WR)
      trig_pulse = input_channel_select_write;
    else
      trig_pulse = 1'b0;
  end

  // rising edge of the selected level, or the access pulse, gives one request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_prev_q <= 1'b0;
      sel_wr_q    <= 1'b0;
      soc_q       <= 1'b0;
    end
    else
    begin
      trig_prev_q <= trig_level;
      sel_wr_q    <= wr_en & is_ofs(wr_addr_q, atts_pkg::OFS_TRIG_SEL); // no false edge
      soc_q       <= (trig_level & ~trig_prev_q & ~sel_wr_q) | trig_pulse;
    end
  end

  // start request straight from its flip-flop
  assign soc_req = soc_q;

  // sticky interrupt status, write one to clear, set wins
  always_comb
  begin
    irq_set = '0;
    irq_set[atts_pkg::IRQ_THRESH] = thr_evt_q;
    irq_set[atts_pkg::IRQ_SOC]    = soc_q;
    irq_set[atts_pkg::IRQ_DONE]   = done_q;
    irq_clr = '0;
    if (wr_en && is_ofs(wr_addr_q, atts_pkg::OFS_IRQ_STATUS))
      irq_clr = wbyte[atts_pkg::IRQ_W-1:0];
  end

  // status register update, clear first then set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irq_stat_q & irq_mask_q);

endmodule

// *** tb/atts_sva.sv ***
// assertions on the ports of the threshold and trigger block
`timescale 1ns/1ps
module atts_sva (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          hsel,
  input wire logic [31:0]                   haddr,
  input wire logic [1:0]                    htrans,
  input wire logic                          hwrite,
  input wire logic [31:0]                   hwdata,
  input wire logic                          hready,
  input wire logic [31:0]                   hrdata,
  input wire logic                          hreadyout,
  input wire logic                          hresp,
  input wire logic                          conv_done,
  input wire logic [atts_pkg::NUM_SRC-1:0]  trigger_sources,
  input wire logic                          result_upper_byte_read,
  input wire logic                          input_channel_select_write,
  input wire logic                          soc_req,
  input wire logic                          threshold_irq,
  input wire logic                          irq
);
  logic       wr_q;
  logic       rd_q;
  logic [7:0] ad_q;
  logic [4:0] sel_q;
  wire        take = hsel && htrans[1] && hready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // bus phase snoop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ad_q <= 8'h00;
    end
    else
    begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      ad_q <= haddr[7:0];
    end
  end
  // shadow of the trigger selector
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sel_q <= 5'h00;
    else if (wr_q && ad_q == atts_pkg::OFS_TRIG_SEL)
      sel_q <= hwdata[4:0];
  end
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RD_UPPER0: assert property (rd_q |-> hrdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  AST_SEL_READ: assert property (rd_q && ad_q == atts_pkg::OFS_TRIG_SEL
    |-> hrdata[7:0] == {3'h0, $past(sel_q)}) else $error("selector read wrong");
  AST_SOC_OFF: assert property (sel_q == 5'h00 && $past(sel_q) == 5'h00 |-> !soc_req)
    else $error("start request with trigger disabled");
  AST_SOC_CHAN: assert property (sel_q == atts_pkg::ACT_CHAN_WR &&
    input_channel_select_write |=> soc_req) else $error("no start on channel write");
  AST_SOC_RES: assert property (sel_q == atts_pkg::ACT_RES_READ &&
    result_upper_byte_read |=> soc_req) else $error("no start on result read");
  AST_SOC_ERR: assert property (sel_q == atts_pkg::ACT_ERR_READ && take && !hwrite &&
    haddr[7:0] == atts_pkg::OFS_ERR_HIGH |=> soc_req) else $error("no start on error read");
  AST_SOC_SRC: assert property (sel_q >= 5'h02 && sel_q <= 5'h19 && sel_q == $past(sel_q)
    && $rose(trigger_sources[sel_q - 5'd2]) |=> soc_req) else $error("source edge missed");
  AST_SOC_ONE: assert property (soc_req && sel_q >= 5'h02 && sel_q <= 5'h19
    |=> !soc_req) else $error("start request longer than one cycle");
  AST_TIRQ_DONE: assert property (threshold_irq |-> $past(conv_done))
    else $error("threshold request without conversion");
  AST_RST_QUIET: assert property ($fell(rst) |-> !soc_req && !threshold_irq && !irq)
    else $error("outputs active after reset");
  COV_SOC: cover property (soc_req);
  COV_TIRQ: cover property (threshold_irq);
  COV_IRQ: cover property ($rose(irq));
endmodule
bind atts_top atts_sva u_sva (.*);

// *** tb/atts_core_model.sv ***
// converter core model answering start requests with a finished conversion
`timescale 1ns/1ps
module atts_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        soc_req,
  input  wire logic [15:0] sample,
  input  wire logic [7:0]  dly,
  output logic      [15:0] conv_result,
  output logic      [15:0] prev_result,
  output logic      [15:0] filter_value,
  output logic             conv_done
);
  logic [7:0] cnt_q;
  logic       busy_q;
  wire        fin = busy_q && cnt_q == 8'h00;
  // hold a start request and finish it after dly cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= fin;
      if (soc_req)
      begin
        busy_q <= 1'b1;
        cnt_q <= dly;
      end
      else if (fin)
        busy_q <= 1'b0;
      else if (busy_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end
  // results change only as a conversion ends
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      conv_result <= 16'h0000;
      prev_result <= 16'h0000;
    end
    else if (fin)
    begin
      prev_result <= conv_result;
      conv_result <= sample;
    end
  end
  assign filter_value = conv_result ^ 16'h5555; // read by error methods 3 and 4
endmodule

// *** tb/atts_top_tb.sv ***
// self-checking bench for the threshold and trigger block
`timescale 1ns/1ps
module atts_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pins = 8'h00;
  logic [23:0] srcs = 24'h0;
  logic        res_rd = 1'b0;
  logic        chan_wr = 1'b0;
  logic [15:0] sample = 16'h0;
  logic [7:0]  dly = 8'h02;
  logic [15:0] c_res;
  logic [15:0] p_res;
  logic [15:0] f_val;
  logic        c_done;
  logic        soc_req;
  logic        t_irq;
  logic        irq;
  logic [31:0] rd;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          soc_cnt = 0;
  int          t_cnt = 0;
  always #10 clk = ~clk;
  // count request pulses
  always @(posedge clk)
  begin
    soc_cnt += (soc_req === 1'b1);
    t_cnt += (t_irq === 1'b1);
  end
  atts_top uut (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_result(c_res), .prev_result(p_res),
    .filter_value(f_val), .conv_done(c_done), .trigger_pins(pins), .trigger_sources(srcs),
    .result_upper_byte_read(res_rd), .input_channel_select_write(chan_wr),
    .soc_req(soc_req), .threshold_irq(t_irq), .irq(irq));
  atts_core_model core (.clk(clk), .rst(rst), .soc_req(soc_req), .sample(sample), .dly(dly),
    .conv_result(c_res), .prev_result(p_res), .filter_value(f_val), .conv_done(c_done));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer, read data kept in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  // one conversion started by a channel write, waits for its end
  task automatic convert(input logic [15:0] s);
    int w;
    sample <= s;
    chan_wr <= 1'b1;
    @(posedge clk);
    chan_wr <= 1'b0;
    for (w = 0; w < 40 && c_done !== 1'b1; w++) @(posedge clk);
    chk("conversion done", 1'b1, c_done);
    repeat (2) @(posedge clk);
  endtask
  task automatic t_regs();
    for (int i = 2; i < 7; i++)
    begin
      rdchk(8'(i * 4), 32'h0);
      bus(1'b1, 8'(i * 4), 32'hffffff5d - i);
      rdchk(8'(i * 4), (i == 6) ? 32'h17 : 32'h5d - i);
    end
    bus(1'b1, 8'h3c, 32'hff);
    rdchk(8'h3c, 32'h0);
  endtask
  task automatic t_thresh();
    logic [15:0] e;
    logic        a;
    logic        b;
    logic        x;
    bus(1'b1, atts_pkg::OFS_LTH_HIGH, 32'h0);
    bus(1'b1, atts_pkg::OFS_LTH_LOW, 32'h10);
    bus(1'b1, atts_pkg::OFS_UTH_HIGH, 32'h01);
    bus(1'b1, atts_pkg::OFS_UTH_LOW, 32'h0);
    bus(1'b1, atts_pkg::OFS_SETPT_LOW, 32'h3);
    bus(1'b1, atts_pkg::OFS_TRIG_SEL, 32'h1d);
    for (int m = 0; m < 8; m++)
      for (int k = 0; k < 3; k++)
      begin
        e = (k == 0) ? 16'h2 : (k == 1) ? 16'h4d : 16'h1fd;
        b = (k == 0);
        a = (k == 2);
        x = (m == 7) | (m == 1 & b) | (m == 2 & !b) | (m == 3 & !a & !b) | (m == 4 & (a | b))
          | (m == 5 & !a) | (m == 6 & a);
        bus(1'b1, atts_pkg::OFS_CTRL_THREE, 32'h10 | m);
        bus(1'b1, atts_pkg::OFS_IRQ_MASK, {31'h0, !m[0]});
        dly <= 8'h02 + m;
        t_cnt = 0;
        convert(e + 16'h3);
        rdchk(atts_pkg::OFS_ERR_HIGH, e[15:8]);
        rdchk(atts_pkg::OFS_ERR_LOW, e[7:0]);
        rdchk(atts_pkg::OFS_CONV_STATUS, {a, b});
        rdchk(atts_pkg::OFS_IRQ_STATUS, {2'b11, x});
        chk("threshold pulses", x, t_cnt);
        chk("irq level", x & !m[0], irq);
        bus(1'b1, atts_pkg::OFS_IRQ_STATUS, 32'h7);
        @(posedge clk);
        chk("irq cleared", 1'b0, irq);
      end
  endtask
  task automatic t_error_select_a();
    logic [15:0] s;
    logic [15:0] p;
    logic [15:0] e;
    bus(1'b1, atts_pkg::OFS_SETPT_HIGH, 32'h01);
    bus(1'b1, atts_pkg::OFS_SETPT_LOW, 32'h20);
    rdchk(atts_pkg::OFS_SETPT_HIGH, 32'h01);
    rdchk(atts_pkg::OFS_SETPT_LOW, 32'h20);
    s = 16'h0345;
    convert(s);
    for (int m = 0; m < 6; m++)
    begin
      bus(1'b1, atts_pkg::OFS_CTRL_THREE, m << 4);
      rdchk(atts_pkg::OFS_CTRL_THREE, m << 4);
      p = s;
      s = s + 16'h0123;
      convert(s);
      case (m)
        0: e = s - p;
        2: e = p - 16'h0120;
        3: e = (s ^ 16'h5555) - 16'h0120;
        4: e = (s ^ 16'h5555) - p;
        default: e = s - 16'h0120;
      endcase
      rdchk(atts_pkg::OFS_ERR_HIGH, e[15:8]);
      rdchk(atts_pkg::OFS_ERR_LOW, e[7:0]);
    end
  endtask
  task automatic t_trig();
    int base;
    bus(1'b1, atts_pkg::OFS_PIN_ROUTE, 32'h3);
    rdchk(atts_pkg::OFS_PIN_ROUTE, 32'h3);
    for (int c = 0; c < 28; c++) // reserved codes are never programmed
    begin
      bus(1'b1, atts_pkg::OFS_TRIG_SEL, c);
      repeat (3) @(posedge clk);
      base = soc_cnt;
      if (c == 26)
        bus(1'b0, atts_pkg::OFS_ERR_HIGH, 32'h0);
      res_rd <= (c == 27);
      pins <= (c == 1) ? 8'h08 : 8'h00;
      srcs <= (c == 0) ? 24'hffffff : (c > 1 && c < 26) ? 24'h1 << (c - 2) : 24'h0;
      @(posedge clk);
      res_rd <= 1'b0;
      repeat (6) @(posedge clk);
      chk("start count", c != 0, soc_cnt - base);
      pins <= 8'h00;
      srcs <= 24'h0;
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_thresh();
    t_error_select_a();
    t_trig();
    give_verdict();
  end
  // watchdog
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict();
  end
endmodule
